// file: frps_rail_model.sv
// Purpose: behavioural downstream regulators fed by the sequencer rail enables
// Assumes: each rail settles a fixed number of cycles after its enable changes
// Notes:   a failing rail never reaches regulation; unused channels 1 to 3 read the internal rail
`timescale 1ns/1ps
`default_nettype none

module frps_rail_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] en,
  input  wire logic [3:0] unused,
  input  wire logic [3:0] fail,
  input  wire logic [7:0] rise_lag,
  input  wire logic [7:0] fall_lag,
  output logic      [3:0] sense
);
  // ------------------------------------------------------------
  // rail levels
  // ------------------------------------------------------------
  logic [3:0] lvl_r;
  logic [7:0] cnt_r [4];

  // a strapped channel above channel 0 sits on the internal regulator rail, so it always reads good
  assign sense = lvl_r | {unused[3:1], 1'b0};

  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (rst || en[i] == lvl_r[i] || (en[i] && fail[i])) begin
        cnt_r[i] <= 8'h00;
        if (rst) begin
          lvl_r[i] <= 1'b0;
        end
      end else if (cnt_r[i] + 8'h01 >= (en[i] ? rise_lag : fall_lag)) begin
        lvl_r[i] <= en[i];
        cnt_r[i] <= 8'h00;
      end else begin
        cnt_r[i] <= cnt_r[i] + 8'h01;
      end
    end
  end
endmodule

`default_nettype wire

// file: frps_timer.sv
// Purpose: package of the four-rail sequencer and its down-counting step/timeout timer
// Assumes: one clock at 25 MHz, synchronous active-high reset
// Notes:   counts are loaded from software-written registers in the top
//
// Summary of operation
// R1 - act only on up rise, down fall
// R2 - up edge: first enable after step delay
// R3 - rail good: next enable after step delay
// R4 - rail off: lower enable drops after delay
// R5 - one step delay, 0.25 to 25 ms
// R6 - rail late: reverse power-down from below
// R7 - down edge: fourth enable low, then descend
// R8 - no regulation timeout during power-down
// R9 - last rail good plus delay: both flags
// R10 - done clears after rail one off, delay
// R11 - power good drops at once on down
// R12 - unused channels skip their step delay
// R13 - controller waits 2.8 ms after lockout exit
// R14 - lockout holds enables and flags low
// R15 - controller ties up and down together
// R16 - ascending up, descending down
// R17 - disabled channel disables all higher ones
// R18 - after lockout, wait for up rise
// R19 - one clock, counts from configuration registers
`timescale 1ns/1ps
`default_nettype none

package frps_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int NCH          = 4;
  localparam int CW           = 20;
  localparam int IW           = 2;
  localparam int CLK_MHZ      = 25;
  localparam int STEP_MIN_US  = 250;
  localparam int STEP_MAX_US  = 25000;
  localparam int TMO_DEF_US   = 25000;
  localparam int STEP_MIN_CYC = STEP_MIN_US * CLK_MHZ;
  localparam int STEP_MAX_CYC = STEP_MAX_US * CLK_MHZ;
  localparam int TMO_DEF_CYC  = TMO_DEF_US * CLK_MHZ;
  localparam int TMO_MIN_CYC  = 1;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_STEP = 4'h0;
  localparam logic [3:0] ADDR_TMO  = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  localparam int STAT_DONE  = 4;
  localparam int STAT_PG    = 5;
  localparam int STAT_IDX   = 8;
  localparam int STAT_LAST  = 12;
  localparam int STAT_STATE = 16;

  typedef enum logic [7:0] {
    ST_WAIT_UP = 8'h01,
    ST_UP_DLY  = 8'h02,
    ST_UP_REG  = 8'h04,
    ST_UP_FIN  = 8'h08,
    ST_ON      = 8'h10,
    ST_DN_DLY  = 8'h20,
    ST_DN_WAIT = 8'h40,
    ST_DN_FIN  = 8'h80
  } frps_state_t;

  typedef struct packed {
    frps_state_t     state;
    logic [IW-1:0]   idx;
    logic [IW-1:0]   last;
    logic [NCH-1:0]  en;
    logic            done;
    logic            pg;
    logic            up_q;
    logic            dn_q;
    logic [CW-1:0]   step;
    logic [CW-1:0]   tmo;
    logic            wait_r;
    logic [31:0]     rdata;
  } frps_regs_t;

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          busy;
  } frps_tmr_t;
endpackage

module frps_timer
  import frps_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          load,
  input  wire logic          stop,
  input  wire logic [CW-1:0] value,
  output logic               expired,
  output logic               busy
);
  localparam logic [CW-1:0] CNT_ONE = 20'h00001;

  frps_tmr_t t_r;
  frps_tmr_t t_nxt;

  assign expired = t_r.busy && (t_r.cnt == CNT_ONE);
  assign busy    = t_r.busy;

  // load wins over stop so a restart in the stopping cycle is kept
  always_comb begin
    t_nxt = t_r;
    if (load) begin
      t_nxt.cnt  = value;
      t_nxt.busy = 1'b1;
    end else if (stop || expired) begin
      t_nxt.busy = 1'b0;
    end else if (t_r.busy) begin
      t_nxt.cnt = t_r.cnt - CNT_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin // [R19]
      t_r <= '0;
    end else begin
      t_r <= t_nxt;
    end
  end
endmodule

`default_nettype wire

// file: frps_top.sv
// Purpose: four-rail power sequencer control with Avalon-MM configuration
// Assumes: pins synchronous to clk; disabled-channel straps steady while sequencing
// Notes:   step delay and regulation timeout are cycle counts in registers
`default_nettype none
`timescale 1ns/1ps

module frps_top
  import frps_pkg::*;
#(
  parameter logic [CW-1:0] STEP_MIN = CW'(STEP_MIN_CYC),
  parameter logic [CW-1:0] STEP_MAX = CW'(STEP_MAX_CYC),
  parameter logic [CW-1:0] TMO_DEF  = CW'(TMO_DEF_CYC)
)
(
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire logic           supply_lockout,
  input  wire logic           up_in,
  input  wire logic           down_n_in,
  input  wire logic [NCH-1:0] rail_sense_in,
  input  wire logic [NCH-1:0] rail_unused_in,
  output logic      [NCH-1:0] rail_enable_out,
  output logic                sequence_complete_flag,
  output logic                power_good_flag,
  input  wire logic [3:0]     avs_address,
  input  wire logic           avs_read,
  input  wire logic           avs_write,
  input  wire logic [31:0]    avs_writedata,
  output logic      [31:0]    avs_readdata,
  output logic                avs_waitrequest
);
  localparam logic [IW-1:0] IDX_ZERO = 2'h0;
  localparam logic [IW-1:0] IDX_ONE  = 2'h1;
  localparam logic [IW-1:0] IDX_TOP  = IW'(NCH - 1);

  frps_regs_t       s_r;
  frps_regs_t       s_nxt;
  logic             dly_load;
  logic             dly_stop;
  logic             dly_exp;
  logic             tmo_load;
  logic             tmo_stop;
  logic             tmo_exp;
  logic             tmo_busy;
  logic             up_rise;
  logic             dn_fall;
  logic [NCH-1:0]   off_chain;
  logic [NCH-1:0]   used_now;
  logic [NCH-1:0]   used_mask;
  logic [IW-1:0]    last_now;
  logic [31:0]      stat;

  // ----------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------
  frps_timer u_step (
    .clk     (clk),
    .rst     (rst),
    .load    (dly_load),
    .stop    (dly_stop),
    .value   (s_r.step),
    .expired (dly_exp),
    .busy    ()
  );

  frps_timer u_tmo (
    .clk     (clk),
    .rst     (rst),
    .load    (tmo_load),
    .stop    (tmo_stop),
    .value   (s_r.tmo),
    .expired (tmo_exp),
    .busy    (tmo_busy)
  );

  // ----------------------------------------------------------------
  // channel use: a disabled channel takes every higher one with it
  // ----------------------------------------------------------------
  assign off_chain[0] = 1'b0;
  assign used_now[0]  = 1'b1;
  genvar g;
  generate
    for (g = 1; g < NCH; g++) begin : g_chan
      assign off_chain[g] = off_chain[g-1] | rail_unused_in[g]; // [R17]
      assign used_now[g]  = ~off_chain[g];
      assign used_mask[g] = (IW'(g) <= s_r.last);
    end
  endgenerate
  assign used_mask[0] = 1'b1;

  always_comb begin
    last_now = IDX_ZERO;
    for (int i = 1; i < NCH; i++) begin
      if (used_now[i]) begin
        last_now = IW'(i);
      end
    end
  end

  assign up_rise = up_in & ~s_r.up_q; // [R1]
  assign dn_fall = ~down_n_in & s_r.dn_q; // [R1]

  always_comb begin
    stat = '0;
    stat[NCH-1:0] = s_r.en;
    stat[STAT_DONE] = s_r.done;
    stat[STAT_PG] = s_r.pg;
    stat[STAT_IDX +: IW] = s_r.idx;
    stat[STAT_LAST +: IW] = s_r.last;
    stat[STAT_STATE +: 8] = s_r.state;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    dly_load = 1'b0;
    dly_stop = 1'b0;
    tmo_load = 1'b0;
    tmo_stop = 1'b0;
    s_nxt.up_q = up_in;
    s_nxt.dn_q = down_n_in;

    // bus slave: one wait state, writes land at the accepting edge
    s_nxt.wait_r = !((avs_read || avs_write) && s_r.wait_r);
    if (avs_read && s_r.wait_r) begin
      case (avs_address)
        ADDR_STEP: s_nxt.rdata = 32'(s_r.step);
        ADDR_TMO:  s_nxt.rdata = 32'(s_r.tmo);
        ADDR_STAT: s_nxt.rdata = stat;
        default:   s_nxt.rdata = 32'h00000000;
      endcase
    end
    if (avs_write && !s_r.wait_r) begin
      case (avs_address)
        ADDR_STEP: begin
          if (avs_writedata < 32'(STEP_MIN)) begin // [R5]
            s_nxt.step = STEP_MIN;
          end else if (avs_writedata > 32'(STEP_MAX)) begin
            s_nxt.step = STEP_MAX;
          end else begin
            s_nxt.step = avs_writedata[CW-1:0];
          end
        end
        ADDR_TMO: begin
          if (avs_writedata < 32'(TMO_MIN_CYC)) begin
            s_nxt.tmo = CW'(TMO_MIN_CYC);
          end else if (avs_writedata > 32'(STEP_MAX)) begin
            s_nxt.tmo = STEP_MAX;
          end else begin
            s_nxt.tmo = avs_writedata[CW-1:0];
          end
        end
        default: begin
        end
      endcase
    end

    case (s_r.state)
      ST_WAIT_UP: begin
        s_nxt.last = last_now;
        if (up_rise) begin
          s_nxt.idx = IDX_ZERO;
          dly_load = 1'b1; // [R2]
          s_nxt.state = ST_UP_DLY;
        end
      end
      ST_UP_DLY: begin
        if (dn_fall) begin
          s_nxt.pg = 1'b0;
          dly_stop = 1'b1;
          if (s_r.idx == IDX_ZERO) begin
            s_nxt.state = ST_WAIT_UP;
          end else begin
            s_nxt.idx = s_r.idx - IDX_ONE;
            dly_load = 1'b1;
            s_nxt.state = ST_DN_DLY;
          end
        end else if (dly_exp) begin
          s_nxt.en[s_r.idx] = 1'b1; // [R2] [R3] [R16]
          tmo_load = 1'b1; // [R6]
          s_nxt.state = ST_UP_REG;
        end
      end
      ST_UP_REG: begin
        if (dn_fall) begin
          s_nxt.pg = 1'b0;
          tmo_stop = 1'b1;
          dly_load = 1'b1;
          s_nxt.state = ST_DN_DLY;
        end else if (rail_sense_in[s_r.idx]) begin
          tmo_stop = 1'b1;
          if (s_r.idx != s_r.last) begin
            s_nxt.idx = s_r.idx + IDX_ONE;
            dly_load = 1'b1; // [R3]
            s_nxt.state = ST_UP_DLY;
          end else if (s_r.last == IDX_TOP) begin
            dly_load = 1'b1; // [R9]
            s_nxt.state = ST_UP_FIN;
          end else begin
            s_nxt.done = 1'b1; // [R9] [R12]
            s_nxt.pg = 1'b1;
            s_nxt.state = ST_ON;
          end
        end else if (tmo_exp) begin
          // a late rail is switched off and the chain unwinds below it
          s_nxt.en[s_r.idx] = 1'b0; // [R6]
          if (s_r.idx == IDX_ZERO) begin
            s_nxt.state = ST_WAIT_UP;
          end else begin
            s_nxt.idx = s_r.idx - IDX_ONE;
            dly_load = 1'b1;
            s_nxt.state = ST_DN_DLY;
          end
        end
      end
      ST_UP_FIN: begin
        if (dn_fall) begin
          dly_load = 1'b1;
          s_nxt.state = ST_DN_DLY;
        end else if (dly_exp) begin
          s_nxt.done = 1'b1; // [R9]
          s_nxt.pg = 1'b1;
          s_nxt.state = ST_ON;
        end
      end
      ST_ON: begin
        if (dn_fall) begin
          s_nxt.pg = 1'b0; // [R11]
          s_nxt.idx = s_r.last;
          if (s_r.last == IDX_TOP) begin
            dly_load = 1'b1; // [R7]
            s_nxt.state = ST_DN_DLY;
          end else begin
            s_nxt.en[s_r.last] = 1'b0; // [R12]
            s_nxt.state = ST_DN_WAIT;
          end
        end
      end
      ST_DN_DLY: begin
        tmo_stop = 1'b1; // [R8]
        if (dly_exp) begin
          s_nxt.en[s_r.idx] = 1'b0; // [R4] [R7] [R16]
          s_nxt.state = ST_DN_WAIT;
        end
      end
      ST_DN_WAIT: begin
        tmo_stop = 1'b1; // [R8]
        if (!rail_sense_in[s_r.idx]) begin
          dly_load = 1'b1; // [R4]
          if (s_r.idx == IDX_ZERO) begin
            s_nxt.state = ST_DN_FIN;
          end else begin
            s_nxt.idx = s_r.idx - IDX_ONE;
            s_nxt.state = ST_DN_DLY;
          end
        end
      end
      ST_DN_FIN: begin
        tmo_stop = 1'b1;
        if (dly_exp) begin
          s_nxt.done = 1'b0; // [R10]
          s_nxt.state = ST_WAIT_UP;
        end
      end
      default: begin
        s_nxt.state = ST_WAIT_UP;
      end
    endcase

    // lockout overrides the sequence, enables and flags, not the bus; up history still tracks so a level
    // already high at release is not taken for an edge
    if (supply_lockout) begin
      s_nxt.state = ST_WAIT_UP; // [R14] [R18]
      s_nxt.en = '0;
      s_nxt.done = 1'b0;
      s_nxt.pg = 1'b0;
      s_nxt.idx = IDX_ZERO;
      dly_load = 1'b0;
      tmo_load = 1'b0;
      dly_stop = 1'b1;
      tmo_stop = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin // [R19]
      s_r <= '{state: ST_WAIT_UP, idx: IDX_ZERO, last: IDX_ZERO, en: '0,
               done: 1'b0, pg: 1'b0, up_q: 1'b0, dn_q: 1'b0, step: STEP_MIN,
               tmo: TMO_DEF, wait_r: 1'b1, rdata: 32'h00000000};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rail_enable_out        = s_r.en;
  assign sequence_complete_flag = s_r.done;
  assign power_good_flag        = s_r.pg;
  assign avs_readdata           = s_r.rdata;
  assign avs_waitrequest        = s_r.wait_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic done_cause;
  logic fin_exp;
  assign done_cause = (s_r.state == ST_UP_FIN && dly_exp)
                   || (s_r.state == ST_UP_REG && rail_sense_in[s_r.idx] && s_r.idx == s_r.last);
  assign fin_exp = (s_r.state == ST_DN_FIN) && dly_exp && !rail_sense_in[0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_up_cmd;
    up_in && !s_r.up_q && !supply_lockout && s_r.state == ST_WAIT_UP;
  endsequence
  sequence s_dn_cmd;
    !down_n_in && s_r.dn_q && !supply_lockout && s_r.state == ST_ON;
  endsequence

  property p_lockout;
    supply_lockout |=> rail_enable_out == '0 && !sequence_complete_flag && !power_good_flag;
  endproperty
  a_lockout: assert property (p_lockout) else $error("outputs not low in lockout"); // [R14]

  property p_start;
    s_up_cmd |=> s_r.state == ST_UP_DLY && rail_enable_out == '0 && s_r.idx == IDX_ZERO;
  endproperty
  a_start: assert property (p_start) else $error("up edge did not start delay"); // [R1]

  property p_gate;
    s_r.state == ST_UP_DLY && !dly_exp && !supply_lockout |=> $stable(rail_enable_out);
  endproperty
  a_gate: assert property (p_gate) else $error("enable before step delay"); // [R2]

  property p_pg_drop;
    s_dn_cmd |=> !power_good_flag && sequence_complete_flag;
  endproperty
  a_pg_drop: assert property (p_pg_drop) else $error("power good not dropped at once"); // [R11]

  property p_no_tmo;
    s_r.state inside {ST_DN_DLY, ST_DN_WAIT, ST_DN_FIN, ST_ON} |-> !tmo_busy;
  endproperty
  a_no_tmo: assert property (p_no_tmo) else $error("timeout running in power-down"); // [R8]

  property p_thermo;
    ((rail_enable_out + 1'b1) & rail_enable_out) == '0;
  endproperty
  a_thermo: assert property (p_thermo) else $error("enables out of channel order"); // [R16]

  property p_unused;
    (rail_enable_out & ~used_mask) == '0;
  endproperty
  a_unused: assert property (p_unused) else $error("unused channel enabled"); // [R17]

  property p_tmo;
    s_r.state == ST_UP_REG && tmo_exp && !rail_sense_in[s_r.idx] && !dn_fall && !supply_lockout
      |=> !rail_enable_out[$past(s_r.idx)] && s_r.state inside {ST_DN_DLY, ST_WAIT_UP};
  endproperty
  a_tmo: assert property (p_tmo) else $error("late rail did not start reverse down"); // [R6]

  property p_done;
    $rose(sequence_complete_flag) |-> power_good_flag && $past(done_cause);
  endproperty
  a_done: assert property (p_done) else $error("flags raised without cause"); // [R9]

  property p_done_clr;
    $fell(sequence_complete_flag) && !$past(supply_lockout) |-> $past(fin_exp);
  endproperty
  a_done_clr: assert property (p_done_clr) else $error("done cleared too early"); // [R10]

  property p_step;
    s_r.step >= STEP_MIN && s_r.step <= STEP_MAX;
  endproperty
  a_step: assert property (p_step) else $error("step delay out of range"); // [R5]
endmodule

`default_nettype wire

// file: tb.sv
// Purpose: self-checking bench for the four-rail sequencer
// Assumes: short step and timeout limits set through the top parameters
// Notes:   spacing checks allow up to three edges of slack for the registered outputs
`timescale 1ns/1ps
`default_nettype none

module tb
  import frps_pkg::*;
;
  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  logic        clk, rst, supply_lockout, up_in, down_n_in;
  logic [3:0]  rail_sense_in, rail_unused_in, rail_enable_out, fail, avs_address;
  logic        sequence_complete_flag, power_good_flag, avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0]  rise_lag, fall_lag;
  int          failures, check_count, n, step;

  frps_top #(.STEP_MIN(20'h00004), .STEP_MAX(20'h00028), .TMO_DEF(20'h00028)) frps_top_i (
    .clk, .rst, .supply_lockout, .up_in, .down_n_in, .rail_sense_in, .rail_unused_in,
    .rail_enable_out, .sequence_complete_flag, .power_good_flag, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);

  frps_rail_model frps_rail_model_i (.clk, .rst, .en(rail_enable_out), .unused(rail_unused_in),
    .fail, .rise_lag, .fall_lag, .sense(rail_sense_in));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
    check_count++;
    if (got < lo || got > hi) begin
      failures++;
      $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask

  // one Avalon access; the request holds until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 20) begin
      failures++;
      $display("BAD bus wait expected low seen high");
      report_and_stop();
    end
  endtask

  task automatic wr_rd(input logic [3:0] a, input logic [31:0] d, input logic [31:0] exp);
    bus(1'b1, a, d);
    bus(1'b0, a, 32'h0);
    chk("reg_readback", exp, rd);
  endtask

  // a single controller drives both start inputs as one signal
  task automatic ctl(input logic v);
    @(posedge clk);
    up_in     <= v;
    down_n_in <= v;
  endtask

  // sel 0 enable, 1 sense, 2 complete flag; cnt counts falling edges
  task automatic wait_for(input int sel, input int ch, input logic v, output int cnt);
    logic s;
    cnt = 0;
    do begin
      @(negedge clk);
      cnt++;
      s = (sel == 0) ? rail_enable_out[ch] : (sel == 1) ? rail_sense_in[ch] : sequence_complete_flag;
    end while (s !== v && cnt < 400);
    if (cnt >= 400) begin
      failures++;
      $display("BAD wait sel %0d ch %0d expected %b seen %b", sel, ch, v, s);
      report_and_stop();
    end
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    failures = 0;
    check_count = 0;
    rst = 1'b1;
    supply_lockout = 1'b1;
    up_in = 1'b0;
    down_n_in = 1'b0;
    rail_unused_in = 4'h0;
    fail = 4'h0;
    rise_lag = 8'h03;
    fall_lag = 8'h03;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, ADDR_STEP, 32'h0);
    chk("step_reset", 32'h4, rd);
    bus(1'b0, ADDR_TMO, 32'h0);
    chk("tmo_reset", 32'h28, rd);
    bus(1'b0, ADDR_STAT, 32'h0);
    chk("stat_reset", 32'h00010000, rd & 32'h00FF00FF);
    // lockout overrides the start inputs; a level held across its exit is no edge
    ctl(1'b1);
    repeat (10) @(negedge clk);
    chk("lock_outs", 32'h0, {26'h0, rail_enable_out, sequence_complete_flag, power_good_flag});
    @(posedge clk);
    supply_lockout <= 1'b0;
    repeat (30) @(negedge clk);
    chk("no_level_start", 32'h0, {27'h0, rail_enable_out, sequence_complete_flag});
    ctl(1'b0);
    repeat (70000) @(posedge clk);
    // full power-up on the reset step delay
    step = 4;
    ctl(1'b1);
    for (int i = 0; i < 4; i++) begin
      if (i > 0) wait_for(1, i - 1, 1'b1, n);
      wait_for(0, i, 1'b1, n);
      chk_rng("en_rise", step, step + 3, n);
      chk("en_order", (32'h2 << i) - 32'h1, {28'h0, rail_enable_out});
    end
    wait_for(1, 3, 1'b1, n);
    wait_for(2, 0, 1'b1, n);
    chk_rng("done_rise", step, step + 3, n);
    chk("pg_rise", 32'h1, {31'h0, power_good_flag});
    bus(1'b0, ADDR_STAT, 32'h0);
    chk("stat_on", 32'h0010003F, rd & 32'h00FF00FF);
    // limits of the one shared delay, the timeout floor, an unmapped place, then new settings
    wr_rd(ADDR_STEP, 32'h1, 32'h4);
    wr_rd(ADDR_STEP, 32'h64, 32'h28);
    wr_rd(ADDR_TMO, 32'h0, 32'h1);
    wr_rd(4'hC, 32'hFFFFFFFF, 32'h0);
    wr_rd(ADDR_STEP, 32'h6, 32'h6);
    wr_rd(ADDR_TMO, 32'h1E, 32'h1E);
    step = 6;
    @(posedge clk);
    up_in <= 1'b0;
    @(posedge clk);
    up_in <= 1'b1;
    repeat (20) @(negedge clk);
    chk("up_ignored", 32'h1F, {27'h0, rail_enable_out, power_good_flag});
    // power-down with rails slower than the timeout
    fall_lag = 8'h3C;
    ctl(1'b0);
    repeat (3) @(negedge clk);
    chk("pg_drop", 32'h1E, {27'h0, rail_enable_out, power_good_flag});
    wait_for(0, 3, 1'b0, n);
    chk("dn_first", 32'h7, {28'h0, rail_enable_out});
    for (int i = 3; i > 0; i--) begin
      wait_for(1, i, 1'b0, n);
      wait_for(0, i - 1, 1'b0, n);
      chk_rng("en_fall", step, step + 3, n);
    end
    chk("done_hold", 32'h1, {31'h0, sequence_complete_flag});
    wait_for(1, 0, 1'b0, n);
    wait_for(2, 0, 1'b0, n);
    chk_rng("done_fall", step, step + 3, n);
    // third rail never regulates
    fall_lag = 8'h03;
    fail = 4'h4;
    ctl(1'b1);
    wait_for(0, 2, 1'b1, n);
    wait_for(0, 2, 1'b0, n);
    chk_rng("tmo_drop", 30, 33, n);
    wait_for(0, 1, 1'b0, n);
    chk("rev_order", 32'h1, {28'h0, rail_enable_out});
    wait_for(0, 0, 1'b0, n);
    chk("tmo_flags", 32'h0, {30'h0, sequence_complete_flag, power_good_flag});
    ctl(1'b0);
    fail = 4'h0;
    repeat (20) @(negedge clk);
    // third channel strapped unused takes the fourth with it
    @(posedge clk);
    rail_unused_in <= 4'h4;
    ctl(1'b1);
    wait_for(1, 1, 1'b1, n);
    wait_for(2, 0, 1'b1, n);
    chk_rng("short_done", 0, 3, n);
    chk("short_en", 32'h3, {28'h0, rail_enable_out});
    // last used channel drops with no delay when the fourth is unused
    ctl(1'b0);
    repeat (2) @(negedge clk);
    chk("short_down", 32'h2, {27'h0, rail_enable_out, power_good_flag});
    @(posedge clk);
    supply_lockout <= 1'b1;
    repeat (2) @(negedge clk);
    chk("lock_mid", 32'h0, {26'h0, rail_enable_out, sequence_complete_flag, power_good_flag});
    report_and_stop();
  end
endmodule

`default_nettype wire
